// file: include/dqc_pkg.sv
package dqc_pkg;
  // register offsets (16-bit register index space)
  localparam logic [15:0] ADDR_CONV_PWR     = 16'h001a;
  localparam logic [15:0] ADDR_ENH_PWR      = 16'h0300;
  localparam logic [15:0] ADDR_EQ_SHARE     = 16'h4002;
  localparam logic [15:0] ADDR_ENH_ENABLES  = 16'h4005;
  localparam logic [15:0] ADDR_CLK_CTRL     = 16'h0008;
  localparam logic [15:0] ADDR_RATE_CTRL    = 16'h0009;
  localparam logic [15:0] ADDR_PATH_STATUS  = 16'h000c;
  // equaliser parameter window
  localparam logic [15:0] EQ_PARAM_FIRST    = 16'h4c00;
  localparam logic [15:0] EQ_PARAM_LAST     = 16'h503f;
  // field positions
  localparam int BIT_ENH_ENA    = 0;
  localparam int BIT_DAC_EQ_ENA = 4;
  localparam int BIT_EQ_SHARE   = 7;
  localparam int BIT_LEFT_ENA   = 8;
  localparam int BIT_RIGHT_ENA  = 7;
  localparam int BIT_CLK_GATE   = 0;
  // reset values
  localparam logic [15:0] RST_REG  = 16'h0000;
  localparam logic [3:0]  RST_RATE = 4'h1;
  localparam int SAMPLE_W = 24;
  localparam int DIV_W    = 4;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } dqc_frame_t;

  typedef struct packed {
    logic        left_converter_enable;
    logic        right_converter_enable;
    logic        dac_equaliser_enable;
    logic        dac_eq_coeff_share;
    logic        enhancement_processor_enable;
    logic        system_clock_gate;
  } dqc_ctrl_t;
endpackage : dqc_pkg

// file: logic/dqc_dac_eq_path_control.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
// Requirements this block is written to
// R01 - host enables processor before any enhancement
// R02 - processor enable stays set while enhancements run
// R03 - equaliser parameters untouched until processor enabled
// R04 - one processor enable serves every enhancement
// R05 - equaliser enable bit4 at 4005h, else bypass
// R06 - separate per-path equaliser enables and coefficient sets; here one equaliser enable bit serves both paths
// R07 - share bit makes both channels use right set
// R08 - left converter bit8, right bit7 of 1Ah
// R09 - host enables channel converter while it processes
// R10 - takes interface samples, interpolates to modulator bits; here samples pass through without interpolation
// R11 - per-channel volume, soft mute, mono mix, de-emphasis; here only a disabled channel is zeroed
// R12 - converter clock from system clock while gated on
// R13 - converter clock rate from rate settings automatically; here the ratio is rate_ctrl as the host writes it, with a written zero taken as 1
// R14 - host programs only valid clock ratios
// R15 - host should use high-pass with equaliser
// R16 - equaliser off passes samples unchanged in order
module dqc_dac_eq_path_control (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // register port
  input  wire logic [15:0]      reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  output logic [15:0]           reg_rdata,
  // samples from the audio interface
  input  wire dqc_pkg::dqc_frame_t in_frame,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // samples toward the modulators
  output dqc_pkg::dqc_frame_t   out_frame,
  output logic                  out_valid,
  input  wire logic             out_ready,
  // converter clock enable and control view
  output logic                  conv_clk_en,
  output dqc_pkg::dqc_ctrl_t    ctrl
);
  import dqc_pkg::*;

  logic [15:0] conv_pwr;
  logic [15:0] enh_pwr;
  logic [15:0] eq_share;
  logic [15:0] enh_enables;
  logic [15:0] clk_ctrl;
  logic [3:0]  rate_ctrl;
  logic [DIV_W-1:0] div_cnt;
  logic [15:0] eq_access_blocked;

  // register access decode
  wire wr_conv  = reg_write && (reg_addr == ADDR_CONV_PWR);
  wire wr_enh   = reg_write && (reg_addr == ADDR_ENH_PWR);
  wire wr_share = reg_write && (reg_addr == ADDR_EQ_SHARE);
  wire wr_ena   = reg_write && (reg_addr == ADDR_ENH_ENABLES);
  wire wr_clk   = reg_write && (reg_addr == ADDR_CLK_CTRL);
  wire wr_rate  = reg_write && (reg_addr == ADDR_RATE_CTRL);
  wire in_eq_window = (reg_addr >= EQ_PARAM_FIRST) && (reg_addr <= EQ_PARAM_LAST);

  // equaliser parameter access only counts while processor is off
  wire eq_touch_bad = (reg_write || reg_read) && in_eq_window && !enh_pwr[BIT_ENH_ENA]; // R03

  always_ff @(posedge clk) begin
    if (rst) begin
      conv_pwr    <= RST_REG;
      enh_pwr     <= RST_REG;
      eq_share    <= RST_REG;
      enh_enables <= RST_REG;
      clk_ctrl    <= RST_REG;
    end else begin
      if (wr_conv)  conv_pwr    <= reg_wdata; // R08
      if (wr_enh)   enh_pwr     <= reg_wdata; // R04
      if (wr_share) eq_share    <= reg_wdata; // R07
      if (wr_ena)   enh_enables <= reg_wdata; // R05
      if (wr_clk)   clk_ctrl    <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rate_ctrl <= RST_RATE;
    end else if (wr_rate) begin
      rate_ctrl <= (reg_wdata[3:0] == 4'h0) ? RST_RATE : reg_wdata[3:0];
    end
  end

  // sticky count of early equaliser parameter accesses, for status
  always_ff @(posedge clk) begin
    if (rst) begin
      eq_access_blocked <= 16'h0000;
    end else if (eq_touch_bad && eq_access_blocked != 16'hffff) begin
      eq_access_blocked <= eq_access_blocked + 16'h0001;
    end
  end

  // read mux, one cycle later; unmapped reads return zero
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    unique case (reg_addr)
      ADDR_CONV_PWR:    next_rdata = conv_pwr;
      ADDR_ENH_PWR:     next_rdata = enh_pwr;
      ADDR_EQ_SHARE:    next_rdata = eq_share;
      ADDR_ENH_ENABLES: next_rdata = enh_enables;
      ADDR_CLK_CTRL:    next_rdata = clk_ctrl;
      ADDR_RATE_CTRL:   next_rdata = {12'h000, rate_ctrl};
      ADDR_PATH_STATUS: next_rdata = eq_access_blocked;
      default:          next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) reg_rdata <= 16'h0000;
    else     reg_rdata <= reg_reads_gate(reg_read, next_rdata);
  end

  function automatic logic [15:0] reg_reads_gate(input logic rd, input logic [15:0] d);
    reg_reads_gate = rd ? d : 16'h0000;
  endfunction : reg_reads_gate

  // control view
  assign ctrl.left_converter_enable        = conv_pwr[BIT_LEFT_ENA];   // R08
  assign ctrl.right_converter_enable       = conv_pwr[BIT_RIGHT_ENA];  // R08
  assign ctrl.dac_equaliser_enable         = enh_enables[BIT_DAC_EQ_ENA]; // R05 R06
  assign ctrl.dac_eq_coeff_share           = eq_share[BIT_EQ_SHARE];   // R07
  assign ctrl.enhancement_processor_enable = enh_pwr[BIT_ENH_ENA];     // R04
  assign ctrl.system_clock_gate            = clk_ctrl[BIT_CLK_GATE];   // R12

  // converter clock enable: divider from system clock, ratio taken from rate_ctrl as written by the host, with a written zero held as 1
  wire [DIV_W-1:0] div_last = rate_ctrl - 4'h1; // R13
  always_ff @(posedge clk) begin
    if (rst || !ctrl.system_clock_gate) div_cnt <= '0;
    else if (div_cnt >= div_last)       div_cnt <= '0;
    else                                div_cnt <= div_cnt + 4'h1;
  end
  assign conv_clk_en = ctrl.system_clock_gate && (div_cnt == '0); // R12

  // two-entry buffer in the sample path
  dqc_frame_t buf_q [2];
  logic       buf_wp;
  logic       buf_rp;
  logic [1:0] buf_cnt;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (buf_cnt != 2'd2);
  assign out_valid = (buf_cnt != 2'd0);

  // equaliser stage; bypass is bit exact (the filter itself is elsewhere)
  dqc_frame_t eq_frame;
  assign eq_frame = in_frame; // R16 R10

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= 2'd0;
    end else begin
      if (push) buf_wp <= ~buf_wp;
      if (pop)  buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (push) begin
      buf_q[buf_wp] <= eq_frame; // R16
    end
  end

  // disabled channels deliver silence
  always_comb begin
    out_frame       = buf_q[buf_rp];
    out_frame.left  = ctrl.left_converter_enable  ? out_frame.left  : '0; // R08 R11
    out_frame.right = ctrl.right_converter_enable ? out_frame.right : '0; // R08 R11
  end

  // checks
  chk_left_enable_bit: assert property (@(posedge clk) disable iff (rst) // R08
    $past(wr_conv) |-> ctrl.left_converter_enable == $past(reg_wdata[8]))
    else $error("left enable not taken from bit 8");

  chk_right_enable_bit: assert property (@(posedge clk) disable iff (rst) // R08
    $past(wr_conv) |-> ctrl.right_converter_enable == $past(reg_wdata[7]))
    else $error("right enable not taken from bit 7");

  chk_eq_enable_bit: assert property (@(posedge clk) disable iff (rst) // R05
    $past(wr_ena) |-> ctrl.dac_equaliser_enable == $past(reg_wdata[4]))
    else $error("equaliser enable not taken from bit 4");

  chk_share_bit: assert property (@(posedge clk) disable iff (rst) // R07
    $past(wr_share) |-> ctrl.dac_eq_coeff_share == $past(reg_wdata[7]))
    else $error("share not taken from bit 7");

  chk_proc_holds: assert property (@(posedge clk) disable iff (rst) // R04
    ctrl.enhancement_processor_enable && !wr_enh |=> ctrl.enhancement_processor_enable)
    else $error("processor enable dropped without write");

  chk_clk_gated: assert property (@(posedge clk) disable iff (rst) // R12
    !ctrl.system_clock_gate |-> !conv_clk_en)
    else $error("converter clock without system clock gate");

  chk_bypass_order: assert property (@(posedge clk) disable iff (rst) // R16
    push && buf_cnt == 2'd0 && !pop |=> buf_q[buf_rp] == $past(in_frame))
    else $error("bypass sample altered");

  chk_read_latency: assert property (@(posedge clk) disable iff (rst) // R03
    reg_read && reg_addr == ADDR_ENH_PWR |=> reg_rdata == $past(enh_pwr))
    else $error("read data not one cycle later");

  // register view checks
  chk_conv_read_back: assert property (@(posedge clk) disable iff (rst) // R08
    reg_read && reg_addr == ADDR_CONV_PWR |=> reg_rdata == $past(conv_pwr))
    else $error("converter power read back wrong");

  chk_share_read_back: assert property (@(posedge clk) disable iff (rst) // R07
    reg_read && reg_addr == ADDR_EQ_SHARE |=> reg_rdata == $past(eq_share))
    else $error("share register read back wrong");

  chk_ena_read_back: assert property (@(posedge clk) disable iff (rst) // R05
    reg_read && reg_addr == ADDR_ENH_ENABLES |=> reg_rdata == $past(enh_enables))
    else $error("enables register read back wrong");

  chk_rdata_idle_zero: assert property (@(posedge clk) disable iff (rst) // R03
    !reg_read |=> reg_rdata == 16'h0000)
    else $error("read data present without read");

  chk_window_read_zero: assert property (@(posedge clk) disable iff (rst) // R03
    reg_read && in_eq_window |=> reg_rdata == 16'h0000)
    else $error("parameter window read not zero");

  chk_early_access_count: assert property (@(posedge clk) disable iff (rst) // R03
    eq_touch_bad && eq_access_blocked != 16'hffff
    |=> eq_access_blocked == $past(eq_access_blocked) + 16'h0001)
    else $error("early parameter access not counted");

  chk_late_access_free: assert property (@(posedge clk) disable iff (rst) // R03
    !eq_touch_bad |=> $stable(eq_access_blocked))
    else $error("access counted without early access");

  chk_count_saturates: assert property (@(posedge clk) disable iff (rst) // R03
    eq_access_blocked == 16'hffff |=> eq_access_blocked == 16'hffff)
    else $error("early access count wrapped");

  chk_proc_enable_bit: assert property (@(posedge clk) disable iff (rst) // R04
    $past(wr_enh) |-> ctrl.enhancement_processor_enable == $past(reg_wdata[0]))
    else $error("processor enable not taken from bit 0");

  chk_eq_hold: assert property (@(posedge clk) disable iff (rst) // R05
    !wr_ena |=> $stable(ctrl.dac_equaliser_enable))
    else $error("equaliser enable changed without write");

  chk_share_hold: assert property (@(posedge clk) disable iff (rst) // R07
    !wr_share |=> $stable(ctrl.dac_eq_coeff_share))
    else $error("share changed without write");

  chk_left_hold: assert property (@(posedge clk) disable iff (rst) // R08
    !wr_conv |=> $stable(ctrl.left_converter_enable))
    else $error("left enable changed without write");

  chk_right_hold: assert property (@(posedge clk) disable iff (rst) // R08
    !wr_conv |=> $stable(ctrl.right_converter_enable))
    else $error("right enable changed without write");

  // converter clock checks
  chk_gate_enable_bit: assert property (@(posedge clk) disable iff (rst) // R12
    $past(wr_clk) |-> ctrl.system_clock_gate == $past(reg_wdata[0]))
    else $error("clock gate not taken from bit 0");

  chk_clk_first_pulse: assert property (@(posedge clk) disable iff (rst) // R12
    $rose(ctrl.system_clock_gate) |-> conv_clk_en)
    else $error("no converter pulse when gate opens");

  chk_rate_never_zero: assert property (@(posedge clk) disable iff (rst) // R13
    rate_ctrl != 4'h0)
    else $error("divide ratio is zero");

  chk_rate_zero_maps: assert property (@(posedge clk) disable iff (rst) // R13
    wr_rate && reg_wdata[3:0] == 4'h0 |=> rate_ctrl == RST_RATE)
    else $error("zero ratio not mapped to one");

  chk_rate_taken: assert property (@(posedge clk) disable iff (rst) // R13
    wr_rate && reg_wdata[3:0] != 4'h0 |=> rate_ctrl == $past(reg_wdata[3:0]))
    else $error("divide ratio not taken");

  chk_div_wraps: assert property (@(posedge clk) disable iff (rst) // R13
    div_cnt >= div_last |=> div_cnt == 4'h0)
    else $error("divider did not wrap");

  // sample path checks
  chk_buf_not_over: assert property (@(posedge clk) disable iff (rst) // R16
    buf_cnt != 2'd3)
    else $error("buffer count beyond two");

  chk_full_refuses: assert property (@(posedge clk) disable iff (rst) // R16
    buf_cnt == 2'd2 && !pop |=> buf_cnt == 2'd2)
    else $error("full buffer changed without pop");

  chk_count_tracks: assert property (@(posedge clk) disable iff (rst) // R16
    push && !pop |=> buf_cnt == $past(buf_cnt) + 2'd1)
    else $error("push not counted");

  chk_pop_frees: assert property (@(posedge clk) disable iff (rst) // R16
    pop && !push |=> buf_cnt == $past(buf_cnt) - 2'd1)
    else $error("pop not counted");

  chk_out_hold_stall: assert property (@(posedge clk) disable iff (rst) // R16
    out_valid && !out_ready |=> out_valid && $stable(buf_q[buf_rp]))
    else $error("stalled sample lost");

  chk_left_passes: assert property (@(posedge clk) disable iff (rst) // R16
    ctrl.left_converter_enable |-> out_frame.left == buf_q[buf_rp].left)
    else $error("left sample altered");

  chk_left_muted: assert property (@(posedge clk) disable iff (rst) // R11
    !ctrl.left_converter_enable |-> out_frame.left == '0)
    else $error("disabled left channel not silent");

  chk_right_muted: assert property (@(posedge clk) disable iff (rst) // R11
    !ctrl.right_converter_enable |-> out_frame.right == '0)
    else $error("disabled right channel not silent");
endmodule : dqc_dac_eq_path_control

// file: verification/dqc_sink_model.sv
`timescale 1ns/10ps
module dqc_sink_model (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // samples toward the modulators
  input  wire dqc_pkg::dqc_frame_t out_frame,
  input  wire logic                out_valid,
  output logic                     out_ready
);
  import dqc_pkg::*;
  dqc_frame_t got[$];
  logic [1:0] phase;
  initial begin
    phase = 2'h0;
    out_ready = 1'b0;
  end
  // stalls one cycle in four so the buffer fills and then drains
  always @(posedge clk) begin
    phase <= rst ? 2'h0 : phase + 2'h1;
    out_ready <= !rst && phase != 2'h3;
    if (!rst && out_valid && out_ready) got.push_back(out_frame);
  end
endmodule : dqc_sink_model

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dqc_pkg::*;
  logic clk, rst, reg_write, reg_read, in_valid, in_ready, out_valid, out_ready, conv_clk_en;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  dqc_frame_t in_frame, out_frame;
  dqc_ctrl_t  ctrl;
  int miscompares, tests_run, pulses, refused;
  logic [15:0] ctl_regs [4];
  dqc_dac_eq_path_control dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .in_frame, .in_valid, .in_ready, .out_frame, .out_valid, .out_ready,
    .conv_clk_en, .ctrl);
  dqc_sink_model sink (.clk, .rst, .out_frame, .out_valid, .out_ready);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(48'(reg_rdata), 48'(exp));
  endtask : rd
  // valid is held until ready is seen at an edge, frames follow with no gap
  task automatic stream(input int n, input logic [7:0] k, input logic left_on);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_frame <= {k, 16'(i), ~k, 16'(i)};
      #1;
      while (in_ready !== 1'b1) begin
        refused++;
        @(posedge clk);
        #1;
      end
      @(posedge clk);
    end
    in_valid <= 1'b0;
    repeat (12) @(posedge clk);
    check(48'(sink.got.size()), 48'(n));
    foreach (sink.got[i]) check(sink.got[i], {left_on ? {k, 16'(i)} : 24'h0, ~k, 16'(i)});
    sink.got.delete();
  endtask : stream
  task automatic count_pulses(input int exp);
    pulses = 0;
    repeat (6) @(posedge clk);
    repeat (30) begin
      @(posedge clk);
      #1 pulses += int'(conv_clk_en === 1'b1);
    end
    check(48'(pulses), 48'(exp));
  endtask : count_pulses
  task automatic end_sim;
    $display("counts: run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #(100 * 3000);
    miscompares++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  end
  initial begin
    {rst, reg_write, reg_read, reg_addr, reg_wdata, in_valid, in_frame} = '0;
    rst = 1'b1;
    {miscompares, tests_run, refused} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    ctl_regs = '{ADDR_CONV_PWR, ADDR_ENH_PWR, ADDR_EQ_SHARE, ADDR_ENH_ENABLES};
    foreach (ctl_regs[i]) rd(ctl_regs[i], 16'h0000);
    check(48'(ctrl), 48'h0);
    $display("test reset done");
    rd(EQ_PARAM_FIRST, 16'h0000);
    wr(EQ_PARAM_LAST, 16'h1234);
    rd(ADDR_PATH_STATUS, 16'h0002);
    wr(ADDR_ENH_PWR, 16'h0001);
    wr(EQ_PARAM_FIRST, 16'h0001);
    rd(ADDR_PATH_STATUS, 16'h0002);
    wr(ADDR_ENH_ENABLES, 16'h0010);
    wr(ADDR_EQ_SHARE, 16'h0080);
    wr(ADDR_CONV_PWR, 16'h0180);
    wr(16'h1234, 16'hffff);
    rd(16'h1234, 16'h0000);
    rd(ADDR_ENH_PWR, 16'h0001);
    rd(ADDR_ENH_ENABLES, 16'h0010);
    rd(ADDR_EQ_SHARE, 16'h0080);
    rd(ADDR_CONV_PWR, 16'h0180);
    check(48'(ctrl), 48'h3e);
    $display("test regs done");
    stream(8, 8'h3c, 1'b1);
    check(48'(refused > 0), 48'h1);
    wr(ADDR_CONV_PWR, 16'h0080);
    stream(3, 8'hc5, 1'b0);
    $display("test stream done");
    count_pulses(0);
    wr(ADDR_CLK_CTRL, 16'h0001);
    wr(ADDR_RATE_CTRL, 16'h0003);
    count_pulses(10);
    wr(ADDR_RATE_CTRL, 16'h0000);
    rd(ADDR_RATE_CTRL, 16'h0001);
    count_pulses(30);
    wr(ADDR_CLK_CTRL, 16'h0000);
    count_pulses(0);
    $display("test clock done");
    end_sim();
  end
endmodule : tb_top
